// [hw/cpwm_defs.vh]
// Purpose: Shared constants of the counter PWM and capture block.
// Assumes: Included by every design file of the block.
// Notes: Offsets are byte addresses on the AHB-Lite bus.
`ifndef CPWM_DEFS_VH
`define CPWM_DEFS_VH
// Register byte offsets.
`define CPWM_OFS_CFG1 8'h00
`define CPWM_OFS_CFG2 8'h04
`define CPWM_OFS_CNT_A 8'h08
`define CPWM_OFS_CNT_B 8'h0C
`define CPWM_OFS_CNT_C 8'h10
`define CPWM_OFS_CNT_D 8'h14
`define CPWM_OFS_PORTB 8'h18
// Fields of counter_config_one.
`define CPWM_CFG1_W 12
`define CPWM_CFG1_PWM_LO 0
`define CPWM_CFG1_PWM_HI 1
`define CPWM_CFG1_CASC_AB 2
`define CPWM_CFG1_CASC_CD 3
`define CPWM_CFG1_EN_LSB 4
`define CPWM_CFG1_DIR_LSB 8
// Fields of counter_config_two.
`define CPWM_CFG2_W 8
`define CPWM_CFG2_RES_LO_LSB 0
`define CPWM_CFG2_RES_HI_LSB 2
`define CPWM_CFG2_EDGE_LSB 4
`define CPWM_CFG2_SRC_LSB 6
// Reset values.
`define CPWM_RST_CFG1 12'h000
`define CPWM_RST_CFG2 8'h00
`define CPWM_RST_CNT 8'h00
`define CPWM_RST_PORTB 2'h0
// Resolution codes and compare masks.
`define CPWM_RES_16 2'h3
`define CPWM_RES_14 2'h2
`define CPWM_RES_12 2'h1
`define CPWM_RES_10 2'h0
`define CPWM_MASK_16 16'hFFFF
`define CPWM_MASK_14 16'h3FFF
`define CPWM_MASK_12 16'h0FFF
`define CPWM_MASK_10 16'h03FF
`define CPWM_MASK_8 16'h00FF
// Capture edge and source codes.
`define CPWM_EDGE_OFF 2'h0
`define CPWM_EDGE_RISE 2'h1
`define CPWM_EDGE_FALL 2'h2
`define CPWM_EDGE_BOTH 2'h3
`define CPWM_SRC_PIN_LO 2'h0
`define CPWM_SRC_PIN_HI 2'h1
`define CPWM_SRC_32K 2'h2
`define CPWM_SRC_1K 2'h3
// AHB constants.
`define CPWM_HTRANS_NONSEQ 2'h2
`define CPWM_HTRANS_SEQ 2'h3
`define CPWM_HRESP_OKAY 1'b0
`define CPWM_RD_ZERO 32'h00000000
`endif

// [hw/cpwm_capture.v]
// Purpose: Edge detection and shadow register of one capture counter.
// Assumes: Source and tick are synchronous to hclk; tick is the counter clock pulse.
// Notes: One instance for each of counters A and B; both share source, edge select and tick, so the two halves capture together.
`timescale 1ns/1ps
`include "cpwm_defs.vh"
module cpwm_capture (
   // Clock and reset
   input wire hclk,
   input wire hresetn,
   // Capture control and source
   input wire [1:0] edge_sel,
   input wire src,
   input wire tick,
   input wire [7:0] value,
   // Results
   output wire [7:0] shadow,
   output wire irq
);
   reg src_prev_ff;
   reg pend_ff;
   reg [7:0] shadow_ff;
   reg irq_ff;
   reg hit;

   always @* begin
      case (edge_sel)
         `CPWM_EDGE_RISE: hit = src & ~src_prev_ff;
         `CPWM_EDGE_FALL: hit = ~src & src_prev_ff;
         `CPWM_EDGE_BOTH: hit = src ^ src_prev_ff;
         default: hit = 1'b0;
      endcase
   end

   // The event is held until the next counter pulse, so the shadow follows the counter domain.
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         src_prev_ff <= 1'b0;
         pend_ff <= 1'b0;
         shadow_ff <= `CPWM_RST_CNT;
         irq_ff <= 1'b0;
      end else begin
         src_prev_ff <= src;
         irq_ff <= 1'b0;
         if (tick && pend_ff) begin
            shadow_ff <= value;
            irq_ff <= 1'b1;
         end
         if (hit) begin
            pend_ff <= 1'b1;
         end else if (tick) begin
            pend_ff <= 1'b0;
         end
      end
   end

   assign shadow = shadow_ff;
   assign irq = irq_ff;
endmodule // cpwm_capture

// [hw/cpwm_top.v]
// Purpose: PWM and capture logic of a four counter timer unit with an AHB-Lite register port.
// Assumes: cnt_tick is a one cycle counter clock pulse from the prescaler; all inputs synchronous.
// Notes: Zero wait state slave; a read in the cycle after a write returns the old value.
// Notes: The transfer size is not decoded, so byte and halfword writes act as word writes.
//
// Implementation choices: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
`include "cpwm_defs.vh"
module cpwm_top (
   // Clock and reset
   input wire hclk,
   input wire hresetn,
   // AHB-Lite slave
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output wire [31:0] hrdata,
   output wire hreadyout,
   output wire hresp,
   // Counter clock pulse and capture sources
   input wire cnt_tick,
   input wire tap_1k,
   input wire tap_32k,
   input wire capture_pin_low,
   input wire capture_pin_high,
   // Port B PWM pins
   output wire pwm_pin_low,
   output wire pwm_pin_high,
   // Capture interrupts
   output wire counter_a_interrupt,
   output wire counter_b_interrupt
);
   reg [`CPWM_CFG1_W-1:0] cfg1_ff;
   reg [`CPWM_CFG2_W-1:0] cfg2_ff;
   reg [7:0] cnt_ff [0:3];
   reg [7:0] code_ff [0:3];
   reg [1:0] portb_ff;
   reg wr_pend_ff;
   reg [7:0] wr_addr_ff;
   reg [31:0] hrdata_ff;
   reg pin_lo_ff;
   reg pin_hi_ff;
   reg [7:0] nxt_cnt [0:3];
   reg [31:0] nxt_rdata;
   reg capt_src;
   integer i;

   wire [7:0] shadow_a;
   wire [7:0] shadow_b;
   wire irq_a;
   wire irq_b;

   // Configuration fields.
   wire pwm_lo = cfg1_ff[`CPWM_CFG1_PWM_LO];
   wire pwm_hi = cfg1_ff[`CPWM_CFG1_PWM_HI];
   wire casc_ab = cfg1_ff[`CPWM_CFG1_CASC_AB];
   wire casc_cd = cfg1_ff[`CPWM_CFG1_CASC_CD];
   wire [3:0] cnt_en = cfg1_ff[`CPWM_CFG1_EN_LSB+3:`CPWM_CFG1_EN_LSB];
   wire [3:0] dir_up = cfg1_ff[`CPWM_CFG1_DIR_LSB+3:`CPWM_CFG1_DIR_LSB];
   wire [1:0] res_lo = cfg2_ff[`CPWM_CFG2_RES_LO_LSB+1:`CPWM_CFG2_RES_LO_LSB];
   wire [1:0] res_hi = cfg2_ff[`CPWM_CFG2_RES_HI_LSB+1:`CPWM_CFG2_RES_HI_LSB];
   wire [1:0] edge_sel = cfg2_ff[`CPWM_CFG2_EDGE_LSB+1:`CPWM_CFG2_EDGE_LSB];
   wire [1:0] src_sel = cfg2_ff[`CPWM_CFG2_SRC_LSB+1:`CPWM_CFG2_SRC_LSB];
   wire capt_on = (edge_sel != `CPWM_EDGE_OFF);

   // Effective direction per counter; PWM pairs ignore the software direction bit.
   wire [3:0] up_eff = dir_up & {pwm_hi ? 2'b00 : 2'b11, pwm_lo ? 2'b00 : 2'b11};

   // Compare mask for a cascaded pair from its resolution field.
   function [15:0] cpwm_mask;
      input [1:0] res;
      begin
         case (res)
            `CPWM_RES_16: cpwm_mask = `CPWM_MASK_16;
            `CPWM_RES_14: cpwm_mask = `CPWM_MASK_14;
            `CPWM_RES_12: cpwm_mask = `CPWM_MASK_12;
            default: cpwm_mask = `CPWM_MASK_10;
         endcase
      end
   endfunction

   // PWM level: only the low resolution bits of the counter take part, giving a 2^res period.
   function cpwm_level;
      input [15:0] cnt;
      input [15:0] code;
      input [15:0] mask;
      begin
         cpwm_level = (code > mask) | ((cnt & mask) <= code);
      end
   endfunction

   // Circular step; natural wrap gives 0xFF or 0xFFFF on underflow and zero on overflow.
   function [15:0] cpwm_step;
      input [15:0] val;
      input up;
      begin
         cpwm_step = up ? val + 16'h0001 : val - 16'h0001;
      end
   endfunction

   // Eight bit step of a lone counter; the carry out of the byte is dropped on purpose.
   function [7:0] cpwm_step8;
      input [7:0] val;
      input up;
      reg [15:0] full;
      begin
         full = cpwm_step({8'h00, val}, up);
         cpwm_step8 = full[7:0];
      end
   endfunction

   // Register select of an 8 bit offset, shared by the write decoders.
   function cpwm_is;
      input [7:0] addr;
      input [7:0] ofs;
      begin
         cpwm_is = (addr == ofs);
      end
   endfunction

   // Counter next values for both pairs.
   always @* begin
      for (i = 0; i < 4; i = i + 1) begin
         nxt_cnt[i] = cnt_ff[i];
      end
      if (cnt_tick) begin
         if (casc_ab) begin
            if (cnt_en[0]) begin
               {nxt_cnt[1], nxt_cnt[0]} = cpwm_step({cnt_ff[1], cnt_ff[0]}, up_eff[0]);
            end
         end else begin
            if (cnt_en[0]) begin
               nxt_cnt[0] = cpwm_step8(cnt_ff[0], up_eff[0]);
            end
            if (cnt_en[1]) begin
               nxt_cnt[1] = cpwm_step8(cnt_ff[1], up_eff[1]);
            end
         end
         if (casc_cd) begin
            if (cnt_en[2]) begin
               {nxt_cnt[3], nxt_cnt[2]} = cpwm_step({cnt_ff[3], cnt_ff[2]}, up_eff[2]);
            end
         end else begin
            if (cnt_en[2]) begin
               nxt_cnt[2] = cpwm_step8(cnt_ff[2], up_eff[2]);
            end
            if (cnt_en[3]) begin
               nxt_cnt[3] = cpwm_step8(cnt_ff[3], up_eff[3]);
            end
         end
      end
   end

   // PWM signals of the two channels.
   wire pwm_a = cpwm_level({8'h00, cnt_ff[0]}, {8'h00, code_ff[0]}, `CPWM_MASK_8);
   wire pwm_ab = cpwm_level({cnt_ff[1], cnt_ff[0]}, {code_ff[1], code_ff[0]}, cpwm_mask(res_lo));
   wire pwm_c = cpwm_level({8'h00, cnt_ff[2]}, {8'h00, code_ff[2]}, `CPWM_MASK_8);
   wire pwm_cd = cpwm_level({cnt_ff[3], cnt_ff[2]}, {code_ff[3], code_ff[2]}, cpwm_mask(res_hi));

   // Channel selection: a cascaded pair drives its 16 bit signal, otherwise the low counter.
   wire ch_lo = casc_ab ? pwm_ab : pwm_a;
   wire ch_hi = casc_cd ? pwm_cd : pwm_c;

   // Capture source multiplexer, shared by both counters.
   always @* begin
      case (src_sel)
         `CPWM_SRC_1K: capt_src = tap_1k;
         `CPWM_SRC_32K: capt_src = tap_32k;
         `CPWM_SRC_PIN_HI: capt_src = capture_pin_high;
         default: capt_src = capture_pin_low;
      endcase
   end

   // Separate detectors with the same source, edge select and tick capture both halves together.
   cpwm_capture u_capt_a (
      .hclk(hclk),
      .hresetn(hresetn),
      .edge_sel(edge_sel),
      .src(capt_src),
      .tick(cnt_tick),
      .value(cnt_ff[0]),
      .shadow(shadow_a),
      .irq(irq_a)
   );

   cpwm_capture u_capt_b (
      .hclk(hclk),
      .hresetn(hresetn),
      .edge_sel(edge_sel),
      .src(capt_src),
      .tick(cnt_tick),
      .value(cnt_ff[1]),
      .shadow(shadow_b),
      .irq(irq_b)
   );

   // Bus address phase decode.
   wire ahb_go = hsel & hready & (htrans == `CPWM_HTRANS_NONSEQ || htrans == `CPWM_HTRANS_SEQ);

   // Only the low 256 bytes are mapped; the rest reads zero and ignores writes.
   wire ahb_unmapped = |haddr[31:8];

   // The two shadows form the 16 bit capture register seen by software.
   wire [15:0] shadow_ab = {shadow_b, shadow_a};
   wire [7:0] rd_cnt_a = capt_on ? shadow_ab[7:0] : cnt_ff[0];
   wire [7:0] rd_cnt_b = capt_on ? shadow_ab[15:8] : cnt_ff[1];

   // Read data captured at the address phase so that the data phase needs no wait state.
   always @* begin
      nxt_rdata = `CPWM_RD_ZERO;
      case (haddr[7:0])
         `CPWM_OFS_CFG1: nxt_rdata = {20'h00000, cfg1_ff};
         `CPWM_OFS_CFG2: nxt_rdata = {24'h000000, cfg2_ff};
         `CPWM_OFS_CNT_A: nxt_rdata = {24'h000000, rd_cnt_a};
         `CPWM_OFS_CNT_B: nxt_rdata = {24'h000000, rd_cnt_b};
         `CPWM_OFS_CNT_C: nxt_rdata = {24'h000000, cnt_ff[2]};
         `CPWM_OFS_CNT_D: nxt_rdata = {24'h000000, cnt_ff[3]};
         `CPWM_OFS_PORTB: nxt_rdata = {30'h00000000, portb_ff};
         default: nxt_rdata = `CPWM_RD_ZERO;
      endcase
      if (ahb_unmapped) begin
         nxt_rdata = `CPWM_RD_ZERO;
      end
   end

   wire wr_cfg1 = wr_pend_ff & cpwm_is(wr_addr_ff, `CPWM_OFS_CFG1);
   wire wr_cfg2 = wr_pend_ff & cpwm_is(wr_addr_ff, `CPWM_OFS_CFG2);
   wire wr_portb = wr_pend_ff & cpwm_is(wr_addr_ff, `CPWM_OFS_PORTB);
   wire [3:0] wr_cnt;
   assign wr_cnt[0] = wr_pend_ff & cpwm_is(wr_addr_ff, `CPWM_OFS_CNT_A);
   assign wr_cnt[1] = wr_pend_ff & cpwm_is(wr_addr_ff, `CPWM_OFS_CNT_B);
   assign wr_cnt[2] = wr_pend_ff & cpwm_is(wr_addr_ff, `CPWM_OFS_CNT_C);
   assign wr_cnt[3] = wr_pend_ff & cpwm_is(wr_addr_ff, `CPWM_OFS_CNT_D);

   // Bus slave and register file.
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_ff <= 1'b0;
         wr_addr_ff <= 8'h00;
         hrdata_ff <= `CPWM_RD_ZERO;
         cfg1_ff <= `CPWM_RST_CFG1;
         cfg2_ff <= `CPWM_RST_CFG2;
         portb_ff <= `CPWM_RST_PORTB;
      end else begin
         wr_pend_ff <= ahb_go & hwrite & ~ahb_unmapped;
         wr_addr_ff <= haddr[7:0];
         if (ahb_go && !hwrite) begin
            hrdata_ff <= nxt_rdata;
         end
         if (wr_cfg1) begin
            cfg1_ff <= hwdata[`CPWM_CFG1_W-1:0];
         end
         if (wr_cfg2) begin
            cfg2_ff <= hwdata[`CPWM_CFG2_W-1:0];
         end
         if (wr_portb) begin
            portb_ff <= hwdata[1:0];
         end
      end
   end

   // Counters and codes; a software write loads both and wins over counting.
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (i = 0; i < 4; i = i + 1) begin
            cnt_ff[i] <= `CPWM_RST_CNT;
            code_ff[i] <= `CPWM_RST_CNT;
         end
      end else begin
         for (i = 0; i < 4; i = i + 1) begin
            if (wr_cnt[i]) begin
               cnt_ff[i] <= hwdata[7:0];
               code_ff[i] <= hwdata[7:0];
            end else begin
               cnt_ff[i] <= nxt_cnt[i];
            end
         end
      end
   end

   // Port B pins and interrupt outputs.
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_lo_ff <= 1'b0;
         pin_hi_ff <= 1'b0;
      end else begin
         pin_lo_ff <= pwm_lo ? ch_lo : portb_ff[0];
         pin_hi_ff <= pwm_hi ? ch_hi : portb_ff[1];
      end
   end

   assign hrdata = hrdata_ff;
   assign hreadyout = 1'b1;
   assign hresp = `CPWM_HRESP_OKAY;
   assign pwm_pin_low = pin_lo_ff;
   assign pwm_pin_high = pin_hi_ff;
   // Capture pulses of both counters are suppressed while the low pair (A and B) is in PWM mode.
   wire irq_gate = ~pwm_lo;
   assign counter_a_interrupt = irq_a & irq_gate;
   assign counter_b_interrupt = irq_b & irq_gate;
endmodule // cpwm_top

// [verif/cpwm_chk.sv]
// Purpose: Port level checker of the PWM and capture block.
// Assumes: Single word writes; hready is tied to hreadyout.
// Notes: Configuration is not visible at the ports, so it is mirrored from bus writes.
`timescale 1ns/1ps
module cpwm_chk (
   // Clock and reset
   input wire hclk,
   input wire hresetn,
   // Bus
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [31:0] hwdata,
   input wire hready,
   input wire hreadyout,
   input wire hresp,
   // Block pins
   input wire cnt_tick,
   input wire pwm_pin_low,
   input wire pwm_pin_high,
   input wire counter_a_interrupt,
   input wire counter_b_interrupt
);
   reg wr_ff;
   reg [7:0] wa_ff;
   reg [11:0] cfg1_ff;
   reg [7:0] cfg2_ff;
   reg [7:0] ca_ff;
   reg [7:0] cb_ff;
   reg [1:0] pb_ff;
   wire [1:0] rs = cfg2_ff[1:0];
   wire [15:0] mask = rs == 2'h3 ? 16'hFFFF : rs == 2'h2 ? 16'h3FFF : rs == 2'h1 ? 16'h0FFF : 16'h03FF;
   wire hi_c = cfg1_ff[0] & (cfg1_ff[2] ? {cb_ff, ca_ff} > mask : ca_ff == 8'hFF);
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_ff <= 1'b0;
         wa_ff <= 8'h00;
         cfg1_ff <= 12'h000;
         cfg2_ff <= 8'h00;
         ca_ff <= 8'h00;
         cb_ff <= 8'h00;
         pb_ff <= 2'h0;
      end else begin
         wr_ff <= hsel & hready & htrans[1] & hwrite & (haddr[31:8] == 24'h000000);
         wa_ff <= haddr[7:0];
         if (wr_ff) begin
            case (wa_ff)
               8'h00: cfg1_ff <= hwdata[11:0];
               8'h04: cfg2_ff <= hwdata[7:0];
               8'h08: ca_ff <= hwdata[7:0];
               8'h0C: cb_ff <= hwdata[7:0];
               8'h18: pb_ff <= hwdata[1:0];
               default: ;
            endcase
         end
      end
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   property p_zero_wait;
      hreadyout && !hresp;
   endproperty
   property p_pwm_quiet;
      cfg1_ff[0] && $past(cfg1_ff[0]) |-> !counter_a_interrupt && !counter_b_interrupt;
   endproperty
   property p_irq_one;
      $rose(counter_a_interrupt) |=> !counter_a_interrupt;
   endproperty
   property p_irq_tick;
      counter_a_interrupt || counter_b_interrupt |-> $past(cnt_tick);
   endproperty
   property p_cap_off;
      (cfg2_ff[5:4] == 2'h0) [*3] |-> !counter_a_interrupt && !counter_b_interrupt;
   endproperty
   property p_pin_lo;
      !cfg1_ff[0] [*2] |-> pwm_pin_low == $past(pb_ff[0]);
   endproperty
   property p_pin_hi;
      !cfg1_ff[1] [*2] |-> pwm_pin_high == $past(pb_ff[1]);
   endproperty
   property p_force_hi;
      hi_c && $past(hi_c) |-> pwm_pin_low;
   endproperty
   a_zero_wait: assert property (p_zero_wait) else $error("bus not zero wait or not OKAY");
   a_pwm_quiet: assert property (p_pwm_quiet) else $error("interrupt in PWM mode");
   a_irq_one: assert property (p_irq_one) else $error("interrupt longer than one cycle");
   a_irq_tick: assert property (p_irq_tick) else $error("interrupt without counter pulse");
   a_cap_off: assert property (p_cap_off) else $error("interrupt with capture off");
   a_pin_lo: assert property (p_pin_lo) else $error("pin low not port value");
   a_pin_hi: assert property (p_pin_hi) else $error("pin high not port value");
   a_force_hi: assert property (p_force_hi) else $error("PWM not held high");
   c_irq: cover property ($rose(counter_a_interrupt));
   c_pwm: cover property (cfg1_ff[0] && $rose(pwm_pin_low));
   c_casc: cover property (cfg1_ff[2] && hi_c && pwm_pin_low);
endmodule // cpwm_chk
bind cpwm_top cpwm_chk i_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .cnt_tick(cnt_tick),
   .pwm_pin_low(pwm_pin_low), .pwm_pin_high(pwm_pin_high), .counter_a_interrupt(counter_a_interrupt),
   .counter_b_interrupt(counter_b_interrupt));

// [verif/cpwm_ext.sv]
// Purpose: Model of the port B pins and the external capture inputs.
// Assumes: Bench drives want, sel and clr just after rising edges.
// Notes: Capture pins follow want one cycle late, like a synchronised source.
`timescale 1ns/1ps
module cpwm_ext (
   // Clock
   input wire hclk,
   // Control from bench
   input wire [1:0] want,
   input wire sel,
   input wire clr,
   // Port B pins
   input wire pwm_pin_low,
   input wire pwm_pin_high,
   // Capture pins and high count
   output reg capture_pin_low,
   output reg capture_pin_high,
   output reg [31:0] highs
);
   initial begin
      capture_pin_low = 1'b0;
      capture_pin_high = 1'b0;
      highs = 32'h00000000;
   end
   always @(posedge hclk) begin
      {capture_pin_high, capture_pin_low} <= want;
      // Pins are taken as push-pull digital outputs, so no pull level is modelled.
      highs <= clr ? 32'h00000000 : highs + {31'h00000000, sel ? pwm_pin_high : pwm_pin_low};
   end
endmodule // cpwm_ext

// [verif/counter_pwm_and_capture_test.sv]
// Purpose: Self-checking bench of the PWM and capture block.
// Assumes: Zero wait slave; one counter pulse per hclk while cnt_tick is high.
// Notes: Longest PWM period checked is 14 bits, 16 bits would need 131072 cycles, past the 90000 cycle limit.
`timescale 1ns/1ps
module counter_pwm_and_capture_test;
   reg hclk = 1'b0;
   reg hresetn = 1'b0;
   reg hsel = 1'b0;
   reg [31:0] haddr = 32'h00000000;
   reg [1:0] htrans = 2'h0;
   reg hwrite = 1'b0;
   reg [31:0] hwdata = 32'h00000000;
   reg cnt_tick = 1'b0, tap_1k = 1'b0, tap_32k = 1'b0, sel = 1'b0, clr = 1'b0, m_done = 1'b0, rd_ph = 1'b0;
   reg [1:0] want = 2'h0, m_sel = 2'h0, ed;
   reg [3:0] init;
   reg [7:0] code;
   wire [31:0] hrdata, highs;
   wire hreadyout, hresp, pwm_pin_low, pwm_pin_high, cap_lo, cap_hi, irq_a, irq_b;
   logic [31:0] exp_q[$];
   logic [31:0] seen;
   integer err_count = 0, checked = 0, cyc = 0, na = 0, nb = 0, seed = 4, i, r;
   always #5 hclk = ~hclk;
   cpwm_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .cnt_tick(cnt_tick), .tap_1k(tap_1k), .tap_32k(tap_32k), .capture_pin_low(cap_lo), .capture_pin_high(cap_hi),
      .pwm_pin_low(pwm_pin_low), .pwm_pin_high(pwm_pin_high), .counter_a_interrupt(irq_a), .counter_b_interrupt(irq_b));
   cpwm_ext i_ext (.hclk(hclk), .want(want), .sel(sel), .clr(clr), .pwm_pin_low(pwm_pin_low),
      .pwm_pin_high(pwm_pin_high), .capture_pin_low(cap_lo), .capture_pin_high(cap_hi), .highs(highs));
   task check(input string n, input logic [31:0] s, input logic [31:0] e);
      checked = checked + 1;
      if (s !== e) begin
         err_count = err_count + 1;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask
   task test_done;
      $display("Comparisons %0d, mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task bus(input logic [31:0] a, input logic [31:0] d, input logic w);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
   endtask
   task rd(input logic [31:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      bus(a, 32'h00000000, 1'b0);
   endtask
   task note(input logic [1:0] s, input logic [31:0] e);
      exp_q.push_back(e);
      @(posedge hclk);
      m_sel <= s;
      m_done <= 1'b1;
      @(posedge hclk);
      m_done <= 1'b0;
   endtask
   task meas(input logic p, input integer n, input logic [31:0] e);
      @(posedge hclk);
      sel <= p;
      clr <= 1'b1;
      @(posedge hclk);
      clr <= 1'b0;
      repeat (n - 1) @(posedge hclk);
      note(2'h0, e);
   endtask
   task setsrc(input logic [3:0] v);
      @(posedge hclk);
      want <= v[1:0];
      tap_32k <= v[2];
      tap_1k <= v[3];
   endtask
   // Results are compared in arrival order, whoever produced the expectation.
   always @(posedge hclk) begin
      cyc = cyc + 1;
      if (irq_a === 1'b1) na = na + 1;
      if (irq_b === 1'b1) nb = nb + 1;
      seen = m_sel == 2'h0 ? highs : m_sel == 2'h1 ? na : nb;
      if (rd_ph && hreadyout === 1'b1) check("hrdata", hrdata, exp_q.pop_front());
      if (m_done) check("measure", seen, exp_q.pop_front());
      rd_ph <= hsel & htrans[1] & ~hwrite & (hreadyout === 1'b1);
      if (cyc == 90000) begin
         err_count = err_count + 1;
         test_done;
      end
   end
   initial begin
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      for (i = 0; i < 7; i = i + 1) rd(4 * i, 32'h00000000);
      bus(32'h00000100, 32'hFFFFFFFF, 1'b1);
      rd(32'h00000100, 32'h00000000);
      rd(32'h00000000, 32'h00000000);
      code = $random(seed);
      bus(32'h04, {24'h000000, code}, 1'b1);
      rd(32'h04, {24'h000000, code});
      bus(32'h18, 32'h00000001, 1'b1);
      rd(32'h18, 32'h00000001);
      cnt_tick <= 1'b1;
      for (i = 0; i < 2; i = i + 1) begin
         code = $random(seed);
         bus(32'h08 + 8 * i, {24'h000000, code}, 1'b1);
         bus(32'h00, (32'h1 << i) | (32'h10 << (2 * i)), 1'b1);
         repeat (4) @(posedge hclk);
         meas(i[0], 256, {24'h000000, code} + 32'h1);
      end
      bus(32'h08, 32'h00000000, 1'b1);
      bus(32'h0C, 32'h00000000, 1'b1);
      bus(32'h00, 32'h00000035, 1'b1);
      for (r = 0; r < 3; r = r + 1) begin
         bus(32'h04, r, 1'b1);
         repeat (4) @(posedge hclk);
         meas(1'b0, 2048 << (2 * r), 32'h2);
      end
      bus(32'h08, 32'h000000FF, 1'b1);
      bus(32'h0C, 32'h000000FF, 1'b1);
      repeat (4) @(posedge hclk);
      meas(1'b0, 300, 32'd300);
      bus(32'h00, 32'h00000000, 1'b1);
      cnt_tick <= 1'b0;
      for (i = 0; i < 4; i = i + 1) begin
         ed = (i == 3) ? 2'h1 : i[1:0] + 2'h1;
         init = (ed == 2'h2) ? 4'hF : 4'h0;
         bus(32'h00, 32'h00000000, 1'b1);
         bus(32'h04, 32'h00000000, 1'b1);
         setsrc(init);
         bus(32'h08, 32'h000000FF, 1'b1);
         bus(32'h0C, 32'h000000FF, 1'b1);
         bus(32'h04, {24'h000000, i[1:0], ed, 4'h0}, 1'b1);
         bus(32'h00, 32'h00000130, 1'b1);
         setsrc(init ^ (4'h1 << i));
         repeat (3) @(posedge hclk);
         cnt_tick <= 1'b1;
         @(posedge hclk);
         cnt_tick <= 1'b0;
         note(2'h1, i + 1);
         note(2'h2, i + 1);
         rd(32'h08, 32'h000000FF);
         rd(32'h0C, 32'h000000FF);
         bus(32'h00, 32'h00000000, 1'b1);
         bus(32'h04, 32'h00000000, 1'b1);
         rd(32'h08, 32'h00000000);
         rd(32'h0C, 32'h000000FE);
      end
      test_done;
   end
endmodule // counter_pwm_and_capture_test
